// ==== design/limit_status_alert_logic.sv ====
// sticky limit status flags, alert masks and active-low alert pin selection
`timescale 1ns/10ps
`include "limit_alert_regs.svh"
//
// Contract
// - out-of-limit result after a comparison sets that channel's flag
// - flags stay set; only a read after the fault ends clears them
// - status read clears set flags whose fault is gone, keeps others
// - primary bit 7 reads 1 while any secondary flag is set
// - primary bits 6,5,4,2,0 are remote2, local, remote1, supply, 2.5V
// - secondary bits 7 and 6 flag diode 2 and diode 1 faults
// - secondary bits 4,3,2 flag fans 3,2,1 below minimum speed
// - secondary bit 5 flags fan 4 slow or throttle timer over limit
// - secondary bit 1 flags overtemperature; bit 0 unused
// - alert held low while fault persists and until its register read
// - masks gate only the alert, never the flag setting
// - primary mask bit 7 suppresses alert for all secondary flags
// - primary mask bits 6,5,4,2,0 suppress their primary sources
// - secondary mask bits 7,6 suppress diode 2 and diode 1 faults
// - secondary mask bit 5 suppresses fan 4 or throttle event
// - secondary mask bits 4..1 suppress fans 3,2,1 and overtemp
// - either of two pins can be selected as the alert output
// - host reads status registers over the serial interface
// - high limit violated when above; low limit when at or below
// - alert output disabled after reset until a pin is selected
module limit_status_alert_logic
    import limit_alert_pkg::*;
(
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    // comparison results: remote2, local, remote1, supply, 2.5V
    input  wire limit_cmp_t remote2Cmp,
    input  wire limit_cmp_t localCmp,
    input  wire limit_cmp_t remote1Cmp,
    input  wire limit_cmp_t supplyCmp,
    input  wire limit_cmp_t v25Cmp,
    // secondary fault levels from the diode, tach and throttle engines
    input  wire sec_fault_t secFault,
    // register access from the serial interface
    input  wire reg_req_t   regReq,
    output logic [7:0]      regRdata,
    // alert pin selection and the two candidate alert pins
    input  wire logic       alertPinA_en,
    input  wire logic       alertPinB_en,
    output logic            alertPinA_n,
    output logic            alertPinA_oe,
    output logic            alertPinB_n,
    output logic            alertPinB_oe
);

    localparam int NPRI = 5;

    logic [7:0] statusPri_r,  statusPri_nxt;
    logic [7:0] statusSec_r,  statusSec_nxt;
    logic [7:0] maskPri_r,    maskPri_nxt;
    logic [7:0] maskSec_r,    maskSec_nxt;
    logic [7:0] rdata_r,      rdata_nxt;
    logic [1:0] pinSel_r,     pinSel_nxt;
    logic       alert_r,      alert_nxt;
    logic [7:0] faultPri_r,   faultPri_nxt;
    logic [7:0] cmpHitPri;
    logic [7:0] cmpDonePri;
    logic [7:0] secLevel;
    logic [7:0] priView;

    limit_cmp_t cmpArr [NPRI];
    localparam int PRI_POS [NPRI] = '{`PRI_REMOTE2_BIT, `PRI_LOCAL_BIT, `PRI_REMOTE1_BIT,
                                      `PRI_SUPPLY_BIT, `PRI_V25_BIT};

    assign cmpArr[0] = remote2Cmp;
    assign cmpArr[1] = localCmp;
    assign cmpArr[2] = remote1Cmp;
    assign cmpArr[3] = supplyCmp;
    assign cmpArr[4] = v25Cmp;

    // strict above high, at or below low
    function automatic logic outOfLimit(input limit_cmp_t c);
        outOfLimit = (c.meas > c.highLimit) || (c.meas <= c.lowLimit);
    endfunction : outOfLimit

    function automatic logic isRead(input reg_req_t r, input logic [7:0] ofs);
        isRead = r.rd && (r.addr == ofs);
    endfunction : isRead

    // per-channel comparison outcome, placed at its status bit
    genvar g;
    generate
        for (g = 0; g < NPRI; g++) begin : g_cmp
            assign cmpHitPri[PRI_POS[g]]  = cmpArr[g].valid && outOfLimit(cmpArr[g]);
            assign cmpDonePri[PRI_POS[g]] = cmpArr[g].valid;
        end
    endgenerate
    assign cmpHitPri[7]  = 1'b0;
    assign cmpHitPri[3]  = 1'b0;
    assign cmpHitPri[1]  = 1'b0;
    assign cmpDonePri[7] = 1'b0;
    assign cmpDonePri[3] = 1'b0;
    assign cmpDonePri[1] = 1'b0;

    assign secLevel = {secFault, 1'b0};

    // summary bit is live from the secondary flags
    assign priView = (statusPri_r & `PRI_USED_MASK)
                   | ({7'h00, |statusSec_r} << `PRI_SUMMARY_BIT);

    always_comb begin
        faultPri_nxt  = faultPri_r;
        statusPri_nxt = statusPri_r;
        statusSec_nxt = statusSec_r;
        maskPri_nxt   = maskPri_r;
        maskSec_nxt   = maskSec_r;
        pinSel_nxt    = pinSel_r;
        rdata_nxt     = rdata_r;
        // latest comparison verdict per primary channel
        faultPri_nxt = (faultPri_r & ~cmpDonePri) | cmpHitPri;
        // read clears only flags whose fault is gone; new hits win
        if (isRead(regReq, `OFS_STATUS_PRI)) begin
            statusPri_nxt = statusPri_r & faultPri_r;
        end
        if (isRead(regReq, `OFS_STATUS_SEC)) begin
            statusSec_nxt = statusSec_r & secLevel;
        end
        statusPri_nxt = (statusPri_nxt | cmpHitPri) & `PRI_USED_MASK;
        statusSec_nxt = (statusSec_nxt | secLevel) & `SEC_USED_MASK;
        // register writes
        if (regReq.wr && regReq.addr == `OFS_MASK_PRI) begin
            maskPri_nxt = regReq.wdata;
        end else if (regReq.wr && regReq.addr == `OFS_MASK_SEC) begin
            maskSec_nxt = regReq.wdata;
        end
        // read data
        if (isRead(regReq, `OFS_STATUS_PRI)) begin
            rdata_nxt = priView;
        end else if (isRead(regReq, `OFS_STATUS_SEC)) begin
            rdata_nxt = statusSec_r;
        end else if (isRead(regReq, `OFS_MASK_PRI)) begin
            rdata_nxt = maskPri_r;
        end else if (isRead(regReq, `OFS_MASK_SEC)) begin
            rdata_nxt = maskSec_r;
        end else if (regReq.rd) begin
            rdata_nxt = 8'h00;
        end
        pinSel_nxt = {alertPinB_en, alertPinA_en};
        // unmasked flags drive the alert; primary bit 7 gates all secondary
        alert_nxt = (|(statusPri_nxt & ~maskPri_r & `PRI_USED_MASK))
                  | ((|(statusSec_nxt & ~maskSec_r)) & ~maskPri_r[7]);
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            statusPri_r <= 8'h00;
            statusSec_r <= 8'h00;
            faultPri_r  <= 8'h00;
            maskPri_r   <= `MASK_PRI_RESET;
            maskSec_r   <= `MASK_SEC_RESET;
            rdata_r     <= 8'h00;
            pinSel_r    <= `PIN_SEL_RESET;
            alert_r     <= 1'b0;
        end else begin
            statusPri_r <= statusPri_nxt;
            statusSec_r <= statusSec_nxt;
            faultPri_r  <= faultPri_nxt;
            maskPri_r   <= maskPri_nxt;
            maskSec_r   <= maskSec_nxt;
            rdata_r     <= rdata_nxt;
            pinSel_r    <= pinSel_nxt;
            alert_r     <= alert_nxt;
        end
    end

    assign regRdata = rdata_r;

    // open-drain: drive low only while alert is active on a selected pin
    assign alertPinA_n  = 1'b0;
    assign alertPinB_n  = 1'b0;
    assign alertPinA_oe = alert_r & pinSel_r[0];
    assign alertPinB_oe = alert_r & pinSel_r[1];

endmodule : limit_status_alert_logic

// ==== design/limit_alert_regs.svh ====
// register offsets, bit positions and reset values of the limit status and alert block
`ifndef LIMIT_ALERT_REGS_SVH
`define LIMIT_ALERT_REGS_SVH
`define OFS_STATUS_PRI    8'h41
`define OFS_STATUS_SEC    8'h42
`define OFS_MASK_PRI      8'h74
`define OFS_MASK_SEC      8'h75
`define PRI_SUMMARY_BIT   7
`define PRI_REMOTE2_BIT   6
`define PRI_LOCAL_BIT     5
`define PRI_REMOTE1_BIT   4
`define PRI_SUPPLY_BIT    2
`define PRI_V25_BIT       0
`define PRI_USED_MASK     8'h75
`define SEC_USED_MASK     8'hFE
`define MASK_PRI_RESET    8'h00
`define MASK_SEC_RESET    8'h00
`define PIN_SEL_RESET     2'h0
`endif

// ==== design/limit_alert_pkg.sv ====
// types shared by the limit status and alert block
package limit_alert_pkg;
    // one limit comparison result
    typedef struct packed {
        logic       valid;
        logic [7:0] meas;
        logic [7:0] lowLimit;
        logic [7:0] highLimit;
    } limit_cmp_t;
    // fault sources of the second status register, bit 7 down to 1
    typedef struct packed {
        logic diode2Fault;
        logic diode1Fault;
        logic fan4OrTimer;
        logic fan3Slow;
        logic fan2Slow;
        logic fan1Slow;
        logic overtemp;
    } sec_fault_t;
    // register read/write port
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;
endpackage : limit_alert_pkg

// ==== testbench/limit_alert_properties.sv ====
// port-level assertions for the limit status and alert block
`timescale 1ns/10ps
`include "limit_alert_regs.svh"
module limit_alert_properties
    import limit_alert_pkg::*;
(
    // watched ports
    input wire logic       clk_sys,
    input wire logic       nrst,
    input wire sec_fault_t secFault,
    input wire reg_req_t   regReq,
    input wire logic [7:0] regRdata,
    input wire logic       alertPinA_en,
    input wire logic       alertPinA_oe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    sequence s_wr_rd;
        regReq.wr && regReq.addr == `OFS_MASK_SEC ##3 regReq.rd && regReq.addr == `OFS_MASK_SEC;
    endsequence
    property p_off; !alertPinA_en [*3] |-> !alertPinA_oe; endproperty
    a_off: assert property (p_off) else $error("alert on while pin disabled");
    property p_unmapped; regReq.rd && regReq.addr == 8'h10 |=> regRdata == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_unused1; regReq.rd && regReq.addr == `OFS_STATUS_PRI |=> (regRdata & 8'h0A) == 8'h00; endproperty
    a_unused1: assert property (p_unused1) else $error("unused primary bit set");
    property p_unused2; regReq.rd && regReq.addr == `OFS_STATUS_SEC |=> !regRdata[0]; endproperty
    a_unused2: assert property (p_unused2) else $error("unused secondary bit set");
    property p_summary; regReq.rd && regReq.addr == `OFS_STATUS_PRI && $past(secFault) != '0 |=> regRdata[7]; endproperty
    a_summary: assert property (p_summary) else $error("summary bit missing");
    property p_ovt; regReq.rd && regReq.addr == `OFS_STATUS_SEC && $past(secFault.overtemp) |=> regRdata[1]; endproperty
    a_ovt: assert property (p_ovt) else $error("overtemp flag missing");
    property p_mask_rb; s_wr_rd |=> regRdata == $past(regReq.wdata, 4); endproperty
    a_mask_rb: assert property (p_mask_rb) else $error("mask readback wrong");
    property p_hold; alertPinA_oe && alertPinA_en && !regReq.rd && !$past(regReq.wr) |=> alertPinA_oe; endproperty
    a_hold: assert property (p_hold) else $error("alert dropped without read");
endmodule : limit_alert_properties

// ==== testbench/host_model.sv ====
// serial-bus host stand-in that issues single register accesses
`timescale 1ns/10ps
module host_model
    import limit_alert_pkg::*;
(
    // register port of the block
    input  wire logic       clk_sys,
    output reg_req_t        regReq,
    input  wire logic [7:0] regRdata
);
    initial regReq = '0;
    // idle cycles show inverted address and data so stale values never match
    task automatic xfer(input logic r, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_sys);
        regReq <= '{rd: r, wr: !r, addr: a, wdata: d};
        @(posedge clk_sys);
        regReq <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
        #1;
        q = regRdata;
    endtask : xfer
endmodule : host_model

// ==== testbench/limit_status_alert_logic_tb_top.sv ====
// self-checking bench for the limit status and alert block
`timescale 1ns/10ps
`include "limit_alert_regs.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; $display("mismatch %0t %h %h", $time, g, e); end end
module limit_status_alert_logic_tb_top
    import limit_alert_pkg::*;
;
    logic       clk_sys = 1'b0;
    logic       nrst = 1'b0;
    limit_cmp_t cmp [5] = '{default: '0};
    sec_fault_t secFault = '0;
    reg_req_t   regReq;
    logic [7:0] regRdata;
    logic       enA = 1'b0;
    logic       enB = 1'b0;
    logic       pinA_oe, pinB_oe;
    logic       pinA_n, pinB_n;
    logic [7:0] q;
    int         n_mismatch = 0;
    int         checked = 0;
    always #5 clk_sys = ~clk_sys;
    limit_status_alert_logic limit_status_alert_logic_inst (.clk_sys(clk_sys), .nrst(nrst), .remote2Cmp(cmp[0]),
        .localCmp(cmp[1]), .remote1Cmp(cmp[2]), .supplyCmp(cmp[3]), .v25Cmp(cmp[4]), .secFault(secFault),
        .regReq(regReq), .regRdata(regRdata), .alertPinA_en(enA), .alertPinB_en(enB), .alertPinA_n(pinA_n),
        .alertPinA_oe(pinA_oe), .alertPinB_n(pinB_n), .alertPinB_oe(pinB_oe));
    host_model host_model_inst (.clk_sys(clk_sys), .regReq(regReq), .regRdata(regRdata));
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        host_model_inst.xfer(1'b1, a, 8'h00, q);
        `CHK(q, e)
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_model_inst.xfer(1'b0, a, d, q);
        @(posedge clk_sys);
        #1;
    endtask : wr
    task automatic pulse(input int ch, input logic [7:0] m);
        @(posedge clk_sys);
        cmp[ch] <= '{1'b1, m, 8'h20, 8'h60};
        @(posedge clk_sys);
        cmp[ch].valid <= 1'b0;
        #1;
    endtask : pulse
    task automatic t_reset();
        `CHK(pinA_oe, 1'b0)
        `CHK(pinB_oe, 1'b0)
        `CHK({pinA_n, pinB_n}, 2'b00)
        rd(`OFS_MASK_PRI, `MASK_PRI_RESET);
        rd(8'h10, 8'h00);
        wr(`OFS_STATUS_PRI, 8'hFF);
        rd(`OFS_STATUS_PRI, 8'h00);
    endtask : t_reset
    task automatic t_primary();
        int pb [5] = '{6, 5, 4, 2, 0};
        for (int ch = 0; ch < 5; ch++) begin
            pulse(ch, ch[0] ? 8'h20 : 8'h61);
            rd(`OFS_STATUS_PRI, 8'h01 << pb[ch]);
            rd(`OFS_STATUS_PRI, 8'h01 << pb[ch]);
            pulse(ch, 8'h60);
            rd(`OFS_STATUS_PRI, 8'h01 << pb[ch]);
            rd(`OFS_STATUS_PRI, 8'h00);
        end
    endtask : t_primary
    task automatic t_secondary();
        for (int i = 0; i < 7; i++) begin
            @(posedge clk_sys);
            secFault <= sec_fault_t'(7'h01 << i);
            rd(`OFS_STATUS_PRI, 8'h80);
            rd(`OFS_STATUS_SEC, 8'h02 << i);
            @(posedge clk_sys);
            secFault <= '0;
            rd(`OFS_STATUS_SEC, 8'h02 << i);
            rd(`OFS_STATUS_SEC, 8'h00);
        end
    endtask : t_secondary
    task automatic t_alert();
        @(posedge clk_sys);
        enA <= 1'b1;
        pulse(3, 8'h00);
        `CHK({pinA_oe, pinB_oe}, 2'b10)
        wr(`OFS_MASK_PRI, 8'h04);
        `CHK(pinA_oe, 1'b0)
        rd(`OFS_STATUS_PRI, 8'h04);
        pulse(3, 8'h30);
        rd(`OFS_STATUS_PRI, 8'h04);
        wr(`OFS_MASK_PRI, 8'h80);
        @(posedge clk_sys);
        secFault <= '{fan1Slow: 1'b1, default: 1'b0};
        @(posedge clk_sys);
        #1;
        `CHK(pinA_oe, 1'b0)
        wr(`OFS_MASK_PRI, 8'h00);
        `CHK(pinA_oe, 1'b1)
        wr(`OFS_MASK_SEC, 8'h04);
        rd(`OFS_MASK_SEC, 8'h04);
        `CHK(pinA_oe, 1'b0)
        @(posedge clk_sys);
        enB <= 1'b1;
        wr(`OFS_MASK_SEC, 8'h00);
        `CHK({pinA_oe, pinB_oe}, 2'b11)
        @(posedge clk_sys);
        secFault <= '0;
        @(posedge clk_sys);
        #1;
        `CHK(pinA_oe, 1'b1)
        rd(`OFS_STATUS_SEC, 8'h04);
        `CHK(pinA_oe, 1'b0)
    endtask : t_alert
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (16) @(posedge clk_sys);
        nrst <= 1'b1;
        t_reset();
        t_primary();
        t_secondary();
        t_alert();
        final_report();
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        final_report();
    end
endmodule : limit_status_alert_logic_tb_top
bind limit_status_alert_logic limit_alert_properties limit_alert_properties_inst (.clk_sys(clk_sys), .nrst(nrst),
    .secFault(secFault), .regReq(regReq), .regRdata(regRdata), .alertPinA_en(alertPinA_en), .alertPinA_oe(alertPinA_oe));
